// file: i2cm_defs.vh
// constants for the single-master i2c controller
// assumes inclusion by bare name from the controller file
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH

// ------------------------------------------------------------
// data and buffer sizes
// ------------------------------------------------------------
`define I2CM_BYTE_W 8
`define I2CM_FIFO_DEPTH 32
`define I2CM_FIFO_AW 5
`define I2CM_FIFO_CW 6
`define I2CM_BIT_LAST 3'h7

// ------------------------------------------------------------
// baud generator
// ------------------------------------------------------------
`define I2CM_BAUD_W 16
`define I2CM_BAUD_RST 16'hFFFF
`define I2CM_BAUD_ONE 16'h0001

// ------------------------------------------------------------
// quarter-bit phases: low1, low2, high1, high2
// ------------------------------------------------------------
`define I2CM_PH_LOW1 2'h0
`define I2CM_PH_LOW2 2'h1
`define I2CM_PH_HIGH1 2'h2
`define I2CM_PH_HIGH2 2'h3

// ------------------------------------------------------------
// controller states
// ------------------------------------------------------------
`define I2CM_S_IDLE 3'h0
`define I2CM_S_START 3'h1
`define I2CM_S_BITS 3'h2
`define I2CM_S_ACK 3'h3
`define I2CM_S_STOP 3'h4
`define I2CM_S_NACKW 3'h5
`define I2CM_S_RHOLD 3'h6

`endif

// file: i2cm_ctrl.v
// single-master i2c controller with receive fifo
// assumes open-drain pins resolved outside; software drives control pulses
// Contract
// - only bus master; no multi-master arbitration in hardware.
// - address, data and acknowledge travel on sda, msb first.
// - pins in bus function are driven open-drain only.
// - slave may hold scl low; master waits until scl rises.
// - sda changes mid clock-low; input sampled mid clock-high.
// - all interrupt sources merge into one request output.
// - transmit needs enable and txi; receive, nack need enable; timer its own enable.
// - nack with no start/stop pending sets flag; start/stop set clears it.
// - after nack, bus stalls until start or stop is set.
// - receive-full sets at ack, clears when the fifo takes the byte; bus held until clear.
// - transmit-empty sets on enable, write address/write data first bit out.
// - data write clears transmit-empty while enabled; transmit irq needs flag and txi.
// - transmit-empty stretches ack start unless start or stop pending.
// - disabled with timer enable, irq each time baud count reaches 1.
// - transmit-empty flag sets regardless of transmit irq enable.
// - transmit dma request needs txi; receive dma follows receive data.
// - start is sda falling while scl high.
// - stop is sda rising while scl high, steered by stop bit.
// - start instead of stop at end gives a repeated start.
// - start waits for start bit and a written data register.
// - flush with start/stop discards pending byte, rearms transmit empty.
`timescale 1ns/10ps
`include "i2cm_defs.vh"

// ------------------------------------------------------------
// receive fifo
// ------------------------------------------------------------
module i2cm_fifo #(
  parameter W = `I2CM_BYTE_W,
  parameter D = `I2CM_FIFO_DEPTH,
  parameter AW = `I2CM_FIFO_AW,
  parameter CW = `I2CM_FIFO_CW
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem_ff [0:D-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [CW-1:0] cnt_ff;
  reg full_ff;
  reg valid_ff;
  wire push;
  wire pop;
  reg [CW-1:0] nxt_cnt;

  assign push = in_valid_i && !full_ff;
  assign pop = out_ready_i && valid_ff;
  assign in_ready_o = !full_ff;
  assign out_valid_o = valid_ff;
  assign out_data_o = mem_ff[rd_ptr_ff];

  always @* begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {CW{1'b0}};
      full_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      full_ff <= (nxt_cnt == D[CW-1:0]);
      valid_ff <= (nxt_cnt != {CW{1'b0}});
    end
  end
endmodule // i2cm_fifo

// ------------------------------------------------------------
// controller
// ------------------------------------------------------------
module i2cm_ctrl (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire controller_enable_i,
  input wire transmit_irq_enable_i,
  input wire baud_timer_irq_enable_i,
  input wire [15:0] baud_reload_i,
  input wire start_set_i,
  input wire stop_set_i,
  input wire flush_set_i,
  input wire nak_set_i,
  input wire tx_write_i,
  input wire [7:0] tx_data_i,
  output wire [7:0] rx_data_o,
  output wire rx_valid_o,
  input wire rx_ready_i,
  output reg transmit_empty_flag_o,
  output reg receive_full_flag_o,
  output reg nack_event_flag_o,
  output reg ack_status_o,
  output reg start_pending_o,
  output reg stop_pending_o,
  output reg irq_o,
  output reg tx_dma_req_o,
  output reg rx_dma_req_o,
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_o,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire [1:0] pin_raw;
  wire [1:0] pin_flt;
  assign pin_raw = {scl_i, sda_i};
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      reg [2:0] s_ff;
      reg flt_ff;
      always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s_ff <= 3'h7;
          flt_ff <= 1'b1;
        end else begin
          s_ff <= {s_ff[1:0], pin_raw[g]};
          if (s_ff[1] == s_ff[2]) begin
            flt_ff <= s_ff[2];
          end
        end
      end
      assign pin_flt[g] = flt_ff;
    end
  endgenerate
  wire scl_in;
  wire sda_in;
  assign scl_in = pin_flt[1];
  assign sda_in = pin_flt[0];

  // ------------------------------------------------------------
  // baud generator
  // ------------------------------------------------------------
  reg [15:0] baud_cnt_ff;
  wire tick;
  assign tick = (baud_cnt_ff == `I2CM_BAUD_ONE);
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      baud_cnt_ff <= `I2CM_BAUD_RST;
    end else if ((baud_cnt_ff <= `I2CM_BAUD_ONE) || (baud_cnt_ff > baud_reload_i)) begin
      // a lowered reload takes effect at once instead of after the old count
      baud_cnt_ff <= baud_reload_i;
    end else begin
      baud_cnt_ff <= baud_cnt_ff - 1'b1;
    end
  end

  // ------------------------------------------------------------
  // receive holding register into fifo
  // ------------------------------------------------------------
  reg [7:0] rxbuf_ff;
  reg receive_full_flag_ff;
  wire rx_in_ready;
  i2cm_fifo #(
    .W(`I2CM_BYTE_W),
    .D(`I2CM_FIFO_DEPTH),
    .AW(`I2CM_FIFO_AW),
    .CW(`I2CM_FIFO_CW)
  ) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(receive_full_flag_ff),
    .in_ready_o(rx_in_ready),
    .in_data_i(rxbuf_ff),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );

  // ------------------------------------------------------------
  // controller state
  // ------------------------------------------------------------
  reg [2:0] state_ff;
  reg [1:0] phase_ff;
  reg [2:0] bitcnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] data_ff;
  reg transmit_empty_flag_ff;
  reg start_ff;
  reg stop_ff;
  reg nack_ff;
  reg nak_ff;
  reg rd_ff;
  reg addr_ff;
  reg sda_low_ff;
  reg nack_seen_ff;
  wire en;
  wire tx_byte;
  wire tx_wait;
  wire stretch;
  wire hold;
  wire adv;
  wire ending;
  assign en = controller_enable_i;
  assign tx_byte = addr_ff || !rd_ff;
  assign tx_wait = tx_byte && transmit_empty_flag_ff && !start_ff && !stop_ff && !(addr_ff && rd_ff);
  assign stretch = (phase_ff == `I2CM_PH_HIGH1) && !scl_in;
  assign hold = ((state_ff == `I2CM_S_ACK) && (phase_ff == `I2CM_PH_LOW1) && tx_wait)
    || ((state_ff == `I2CM_S_START) && (phase_ff == `I2CM_PH_LOW1) && transmit_empty_flag_ff);
  assign adv = tick && !stretch && !hold;
  assign ending = adv && (phase_ff == `I2CM_PH_HIGH2);

  // no arbitration logic: this end is always the only master
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= `I2CM_S_IDLE;
      phase_ff <= `I2CM_PH_LOW1;
      bitcnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      data_ff <= 8'h00;
      rxbuf_ff <= 8'h00;
      transmit_empty_flag_ff <= 1'b1;
      receive_full_flag_ff <= 1'b0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
      nack_ff <= 1'b0;
      nak_ff <= 1'b0;
      rd_ff <= 1'b0;
      addr_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      nack_seen_ff <= 1'b0;
    end else begin
      if (tx_write_i) begin
        data_ff <= tx_data_i;
        transmit_empty_flag_ff <= 1'b0;
      end
      if (start_set_i || stop_set_i) begin
        nack_ff <= 1'b0;
        if (flush_set_i) begin
          transmit_empty_flag_ff <= 1'b1;
        end
      end
      if (nak_set_i) begin
        nak_ff <= 1'b1;
      end
      if (receive_full_flag_ff && rx_in_ready) begin
        receive_full_flag_ff <= 1'b0;
      end
      if (start_set_i) begin
        start_ff <= 1'b1;
      end
      if (stop_set_i) begin
        stop_ff <= 1'b1;
      end
      if (adv) begin
        phase_ff <= phase_ff + 1'b1;
      end
      if (!en) begin
        transmit_empty_flag_ff <= 1'b1;
        state_ff <= `I2CM_S_IDLE;
        phase_ff <= `I2CM_PH_LOW1;
        sda_low_ff <= 1'b0;
      end else begin
        case (state_ff)
          `I2CM_S_IDLE: begin
            phase_ff <= `I2CM_PH_LOW1;
            if (start_ff && !transmit_empty_flag_ff && tick) begin
              state_ff <= `I2CM_S_START;
            end
          end
          `I2CM_S_START: begin
            if (adv && phase_ff == `I2CM_PH_LOW1) begin
              sda_low_ff <= 1'b0;
            end
            if (adv && phase_ff == `I2CM_PH_HIGH1) begin
              sda_low_ff <= 1'b1;
            end
            if (ending) begin
              state_ff <= `I2CM_S_BITS;
              shift_ff <= data_ff;
              rd_ff <= data_ff[0];
              addr_ff <= 1'b1;
              bitcnt_ff <= 3'h0;
              start_ff <= start_set_i;
              transmit_empty_flag_ff <= ~data_ff[0];
            end
          end
          `I2CM_S_BITS: begin
            if (adv && phase_ff == `I2CM_PH_LOW1) begin
              sda_low_ff <= tx_byte & ~shift_ff[7];
            end
            if (adv && phase_ff == `I2CM_PH_HIGH1) begin
              shift_ff <= {shift_ff[6:0], sda_in};
            end
            if (ending) begin
              bitcnt_ff <= bitcnt_ff + 1'b1;
              if (bitcnt_ff == `I2CM_BIT_LAST) begin
                state_ff <= `I2CM_S_ACK;
                if (!tx_byte) begin
                  rxbuf_ff <= shift_ff;
                  receive_full_flag_ff <= 1'b1;
                end
              end
            end
          end
          `I2CM_S_ACK: begin
            if (adv && phase_ff == `I2CM_PH_LOW1) begin
              sda_low_ff <= ~tx_byte & ~nak_ff;
            end
            if (adv && phase_ff == `I2CM_PH_HIGH1) begin
              nack_seen_ff <= tx_byte ? sda_in : nak_ff;
            end
            if (ending) begin
              if (nack_seen_ff && !start_ff && !stop_ff) begin
                nack_ff <= 1'b1;
                state_ff <= `I2CM_S_NACKW;
              end else if (stop_ff) begin
                state_ff <= `I2CM_S_STOP;
              end else if (start_ff) begin
                state_ff <= `I2CM_S_START;
              end else if (rd_ff) begin
                state_ff <= `I2CM_S_RHOLD;
              end else begin
                state_ff <= `I2CM_S_BITS;
                shift_ff <= data_ff;
                addr_ff <= 1'b0;
                transmit_empty_flag_ff <= 1'b1;
              end
            end
          end
          `I2CM_S_RHOLD: begin
            phase_ff <= `I2CM_PH_LOW1;
            if (!receive_full_flag_ff) begin
              state_ff <= `I2CM_S_BITS;
              addr_ff <= 1'b0;
            end
          end
          `I2CM_S_NACKW: begin
            phase_ff <= `I2CM_PH_LOW1;
            if (stop_ff) begin
              state_ff <= `I2CM_S_STOP;
            end else if (start_ff) begin
              state_ff <= `I2CM_S_START;
            end
          end
          `I2CM_S_STOP: begin
            if (adv && phase_ff == `I2CM_PH_LOW1) begin
              sda_low_ff <= 1'b1;
            end
            if (adv && phase_ff == `I2CM_PH_HIGH1) begin
              sda_low_ff <= 1'b0;
            end
            if (ending) begin
              state_ff <= `I2CM_S_IDLE;
              stop_ff <= stop_set_i;
              nak_ff <= nak_set_i;
            end
          end
          default: begin
            state_ff <= `I2CM_S_IDLE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pins, flags, interrupt and dma requests
  // ------------------------------------------------------------
  wire scl_pull;
  assign scl_pull = (state_ff == `I2CM_S_NACKW) || (state_ff == `I2CM_S_RHOLD)
    || ((state_ff != `I2CM_S_IDLE) && !phase_ff[1]);
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      transmit_empty_flag_o <= 1'b1;
      receive_full_flag_o <= 1'b0;
      nack_event_flag_o <= 1'b0;
      ack_status_o <= 1'b0;
      start_pending_o <= 1'b0;
      stop_pending_o <= 1'b0;
      irq_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_o <= en & scl_pull;
      sda_oe_o <= en & sda_low_ff;
      transmit_empty_flag_o <= transmit_empty_flag_ff;
      receive_full_flag_o <= receive_full_flag_ff;
      nack_event_flag_o <= nack_ff;
      if (state_ff == `I2CM_S_ACK && ending && tx_byte) begin
        ack_status_o <= ~nack_seen_ff;
      end
      start_pending_o <= start_ff;
      stop_pending_o <= stop_ff;
      irq_o <= (en & transmit_empty_flag_ff & transmit_irq_enable_i)
        | (en & (receive_full_flag_ff | nack_ff))
        | (~en & baud_timer_irq_enable_i & tick);
      tx_dma_req_o <= en & transmit_empty_flag_ff & transmit_irq_enable_i;
      rx_dma_req_o <= rx_valid_o;
    end
  end
endmodule // i2cm_ctrl

// file: i2cm_ctrl_asserts.sv
// port assertions for the i2c controller
// assumes a bind from the bench top, pins resolved with pull-ups
`timescale 1ns/10ps
module i2cm_ctrl_asserts (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire controller_enable_i,
  input wire transmit_irq_enable_i,
  input wire start_set_i,
  input wire stop_set_i,
  input wire tx_write_i,
  input wire transmit_empty_flag_o,
  input wire nack_event_flag_o,
  input wire start_pending_o,
  input wire stop_pending_o,
  input wire irq_o,
  input wire tx_dma_req_o,
  input wire scl_o,
  input wire scl_oe_o,
  input wire sda_o,
  input wire sda_oe_o
);
  // ------------------------------------------------------------
  // helper and properties
  // ------------------------------------------------------------
  reg ctl_seen_ff;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i)
      ctl_seen_ff <= 1'b0;
    else if (start_set_i || stop_set_i)
      ctl_seen_ff <= 1'b1;
    else if ($rose(nack_event_flag_o))
      ctl_seen_ff <= 1'b0;
  end
  sequence s_nack_wait;
    (nack_event_flag_o && !start_pending_o && !stop_pending_o) [*8];
  endsequence
  sequence s_sda_move_scl_free;
    controller_enable_i && !scl_oe_o;
  endsequence
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  AST_WRITE_CLEARS: assert property (
    tx_write_i && controller_enable_i |-> ##2 !transmit_empty_flag_o)
    else $error("write left empty flag set");
  AST_TX_IRQ: assert property (
    controller_enable_i && transmit_irq_enable_i && transmit_empty_flag_o
    |-> ##[0:2] irq_o)
    else $error("transmit irq missing");
  AST_TX_DMA_GATE: assert property (!transmit_irq_enable_i [*3] |-> !tx_dma_req_o)
    else $error("tx dma without enable");
  AST_NACK_STALL: assert property (s_nack_wait |-> $stable(scl_oe_o) && $stable(sda_oe_o))
    else $error("bus moved in nack stall");
  AST_NACK_CLEAR: assert property ($fell(nack_event_flag_o) |-> ctl_seen_ff)
    else $error("nack flag cleared alone");
  AST_START_COND: assert property (
    $rose(sda_oe_o) ##0 s_sda_move_scl_free
    |-> start_pending_o || $past(start_pending_o))
    else $error("sda fell with scl free");
  AST_STOP_COND: assert property (
    $fell(sda_oe_o) ##0 s_sda_move_scl_free
    |-> stop_pending_o || $past(stop_pending_o))
    else $error("sda rose with scl free");
endmodule // i2cm_ctrl_asserts

// file: i2cm_slave_model.sv
// behavioural i2c slave for the bench
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/10ps
module i2cm_slave_model (
  input wire scl_i,
  input wire sda_i,
  input wire nack_i,
  input wire [7:0] rd_byte_i,
  input wire [15:0] stretch_i,
  output reg scl_pull_o,
  output reg sda_pull_o
);
  // ------------------------------------------------------------
  // byte engine
  // ------------------------------------------------------------
  reg [7:0] got [0:7];
  reg [7:0] sh = 8'h00;
  reg rd = 1'b0;
  reg act = 1'b0;
  reg first = 1'b0;
  integer bit_n = 0;
  integer cnt = 0;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
  end
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    bit_n = 0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (bit_n < 8)
      sh = {sh[6:0], sda_i};
    else if (rd && !first && sda_i)
      act = 1'b0;
    if (bit_n == 8 && (first || !rd)) begin
      got[cnt % 8] = sh;
      cnt = cnt + 1;
    end
    if (bit_n == 8 && first)
      rd = sh[0];
    if (bit_n == 8)
      first = 1'b0;
    bit_n = (bit_n == 8) ? 0 : bit_n + 1;
  end
  always @(negedge scl_i) if (act) begin
    if (bit_n == 8)
      sda_pull_o = (first || !rd) && !nack_i;
    else if (rd && !first)
      sda_pull_o = !rd_byte_i[7 - bit_n];
    else
      sda_pull_o = 1'b0;
    if (bit_n == 0 && !first) begin
      scl_pull_o = 1'b1;
      #(stretch_i) scl_pull_o = 1'b0;
    end
  end
endmodule // i2cm_slave_model

// file: i2cm_ctrl_tb_top.sv
// bench top: drives the controller and checks it against the slave model
// assumes design, checker and slave model are compiled first
`timescale 1ns/10ps
module i2cm_ctrl_tb_top;
  // ------------------------------------------------------------
  // stimulus, tasks and sequence
  // ------------------------------------------------------------
  reg clk_sys_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg en = 1'b0;
  reg transmit_irq_enable = 1'b0;
  reg bti = 1'b0;
  reg st = 1'b0;
  reg sp = 1'b0;
  reg fl = 1'b0;
  reg nk = 1'b0;
  reg txw = 1'b0;
  reg rxr = 1'b0;
  reg sl_nack = 1'b0;
  reg [7:0] txd = 8'h00;
  reg [15:0] baud = 16'h0004;
  reg [15:0] stretch = 16'h0028;
  wire [7:0] rxd;
  wire rxv, tef, rff, nef, ack, stp, spp, irq, tdr, rdr, scl_oe, sda_oe, s_scl, s_sda;
  wire scl = !(scl_oe || s_scl);
  wire sda = !(sda_oe || s_sda);
  integer err_total = 0;
  integer num_checks = 0;
  integer n = 0;
  always #2 clk_sys_i = !clk_sys_i;
  i2cm_ctrl i2cm_ctrl_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .controller_enable_i(en), .transmit_irq_enable_i(transmit_irq_enable), .baud_timer_irq_enable_i(bti),
    .baud_reload_i(baud), .start_set_i(st), .stop_set_i(sp), .flush_set_i(fl),
    .nak_set_i(nk), .tx_write_i(txw), .tx_data_i(txd), .rx_data_o(rxd), .rx_valid_o(rxv),
    .rx_ready_i(rxr), .transmit_empty_flag_o(tef), .receive_full_flag_o(rff),
    .nack_event_flag_o(nef), .ack_status_o(ack), .start_pending_o(stp),
    .stop_pending_o(spp), .irq_o(irq), .tx_dma_req_o(tdr), .rx_dma_req_o(rdr),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
  i2cm_slave_model i2cm_slave_model_i (.scl_i(scl), .sda_i(sda), .nack_i(sl_nack),
    .rd_byte_i(8'hC3), .stretch_i(stretch), .scl_pull_o(s_scl), .sda_pull_o(s_sda));
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp, input [63:0] nm);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // control pulse {start, stop, flush, nak} and optional data write
  task drv(input [3:0] p, input w, input [7:0] d);
    begin
      {st, sp, fl, nk} = p;
      txw = w;
      txd = d;
      @(negedge clk_sys_i);
      {st, sp, fl, nk} = 4'h0;
      txw = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  task wt(input [1:0] sel);
    integer k;
    reg hit;
    begin
      hit = 1'b0;
      for (k = 0; k < 20000 && !hit; k = k + 1) begin
        @(negedge clk_sys_i);
        case (sel)
          2'h0: hit = (tef === 1'b1);
          2'h1: hit = (stp === 1'b0 && spp === 1'b0);
          2'h2: hit = (nef === 1'b1);
          default: hit = (rxv === 1'b1);
        endcase
      end
      if (!hit) begin
        err_total = err_total + 1;
        report_and_stop;
      end
    end
  endtask
  task drain;
    integer k;
    begin
      for (k = 0; k < 40 && rxv === 1'b1; k = k + 1) begin
        chk(rxd, 8'hC3, "rxdata");
        rxr = 1'b1;
        @(negedge clk_sys_i);
        rxr = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        n = n + 1;
      end
    end
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk({tef, rff, nef, irq, scl_oe, sda_oe}, 8'h20, "rstval");
    en = 1'b1;
    transmit_irq_enable = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk({irq, tdr}, 8'h03, "txirq");
    drv(4'h0, 1'b1, 8'hA4);
    chk({tef, irq}, 8'h00, "txwrite");
    drv(4'h8, 1'b0, 8'h00);
    wt(2'h0);
    chk(i2cm_slave_model_i.cnt[7:0], 8'h00, "firstbit");
    drv(4'h0, 1'b1, 8'h5A);
    wt(2'h0);
    repeat (300) @(negedge clk_sys_i);
    chk({i2cm_slave_model_i.cnt[3:0], scl_oe}, 8'h03, "ackhold");
    drv(4'h4, 1'b0, 8'h00);
    wt(2'h1);
    chk(i2cm_slave_model_i.got[0], 8'hA4, "byte0");
    chk(i2cm_slave_model_i.got[1], 8'h5A, "byte1");
    chk({ack, scl, sda}, 8'h07, "stopline");
    transmit_irq_enable = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    chk({tef, tdr, irq}, 8'h04, "polltx");
    sl_nack = 1'b1;
    drv(4'h0, 1'b1, 8'hB0);
    drv(4'h8, 1'b0, 8'h00);
    wt(2'h0);
    drv(4'h0, 1'b1, 8'h11);
    wt(2'h2);
    chk(irq, 8'h01, "nackirq");
    repeat (200) @(negedge clk_sys_i);
    chk({scl_oe, nef}, 8'h03, "nackhold");
    drv(4'h6, 1'b0, 8'h00);
    wt(2'h1);
    chk({nef, tef}, 8'h01, "flush");
    sl_nack = 1'b0;
    drv(4'h0, 1'b1, 8'hB1);
    drv(4'h8, 1'b0, 8'h00);
    wt(2'h3);
    @(negedge clk_sys_i);
    chk(rxd, 8'hC3, "rxfirst");
    chk({7'h00, rdr}, 8'h01, "rxdma");
    repeat (6000) @(negedge clk_sys_i);
    chk({rff, scl_oe}, 8'h03, "rxfull");
    drv(4'h5, 1'b0, 8'h00);
    drain;
    wt(2'h1);
    drain;
    chk({(n >= 32), rxv, scl, sda}, 8'h0B, "rxdrain");
    en = 1'b0;
    bti = 1'b1;
    baud = 16'h0008;
    repeat (20) @(negedge clk_sys_i);
    n = 0;
    repeat (80) begin
      @(negedge clk_sys_i);
      n = n + (irq === 1'b1);
    end
    chk(n[7:0], 8'h0A, "timer");
    bti = 1'b0;
    drv(4'h0, 1'b1, 8'h77);
    repeat (20) @(negedge clk_sys_i);
    chk({irq, tef}, 8'h01, "disabled");
    report_and_stop;
  end
endmodule // i2cm_ctrl_tb_top
bind i2cm_ctrl i2cm_ctrl_asserts i2cm_ctrl_asserts_i (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .controller_enable_i(controller_enable_i),
  .transmit_irq_enable_i(transmit_irq_enable_i),
  .start_set_i(start_set_i),
  .stop_set_i(stop_set_i),
  .tx_write_i(tx_write_i),
  .transmit_empty_flag_o(transmit_empty_flag_o),
  .nack_event_flag_o(nack_event_flag_o),
  .start_pending_o(start_pending_o),
  .stop_pending_o(stop_pending_o),
  .irq_o(irq_o),
  .tx_dma_req_o(tx_dma_req_o),
  .scl_o(scl_o),
  .scl_oe_o(scl_oe_o),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o)
);
